// ===== design/alsm_defs.svh
`ifndef ALSM_DEFS_SVH
`define ALSM_DEFS_SVH
// Contract
// - check variant and identity after links established
// - matching identity permits link identification start
// - identification done invokes telephony restart
// - no telephony link request unless provisioned
// - local restart requests all, starts both timers
// - stop each restart timer on its answer
// - both answers in, send restart complete
// - restart timer expiry reports failure, abandons
// - integrity timer periodically reenters startup
// - peer restart forwards request, starts telephony timer
// - peer restart acks stop timer, send complete
// - peer restart timer expiry raises error
// - startup sends establish requests to every needed link
// - control or linkctl up sends start traffic
// - control indication at startup restarts handshake
// - release marks channel down, switches, reports
// - no second switch before link reaches up
// - first request after switch starts setup timer
// - telephony setup expiry blocks ports, unblock later
// - control setup expiry stops traffic, retry timer
// - linkctl setup expiry stops traffic, retry timer
// - one protection failure reported, both disable
// - telephony restart timer runs one hundred seconds
// - timer tolerance better than five percent

// ----------------------------------------
// timing
// ----------------------------------------
`define ALSM_CLK_HZ            10000000
`define ALSM_TICK_CYC          (`ALSM_CLK_HZ)
`define ALSM_TEL_RESTART_S     100
`define ALSM_CTL_RESTART_S     120
`define ALSM_LINK_SETUP_S      15
`define ALSM_LINK_RETRY_S      60
`define ALSM_INTEGRITY_S       300
// link index positions
`define ALSM_L_CTL             0
`define ALSM_L_LCT             1
`define ALSM_L_BCC             2
`define ALSM_L_TEL             3
`define ALSM_L_PR1             4
`define ALSM_L_PR2             5
`define ALSM_NLINK             6
`endif

// ===== design/alsm_pkg.sv
package alsm_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ESTAB,
      ST_IDENT,
      ST_LINKID,
      ST_RESTART,
      ST_RUN,
      ST_ABANDON
   } alsm_state_e;
   typedef logic [8:0] alsm_sec_t;
endpackage

// ===== design/alsm_top.sv
`include "alsm_defs.svh"
module alsm_top #(
   parameter int TICK_CYC     = `ALSM_TICK_CYC,
   parameter int TEL_RST_S    = `ALSM_TEL_RESTART_S,
   parameter int CTL_RST_S    = `ALSM_CTL_RESTART_S,
   parameter int SETUP_S      = `ALSM_LINK_SETUP_S,
   parameter int RETRY_S      = `ALSM_LINK_RETRY_S,
   parameter int INTEG_S      = `ALSM_INTEGRITY_S
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   // provisioning and start
   input  wire logic       start_i,
   input  wire logic       tel_prov_i,
   input  wire logic       secondary_i,
   input  wire logic       local_restart_i,
   // data links, one bit per link
   input  wire logic [5:0] link_setup_confirm_i,
   input  wire logic [5:0] link_setup_indication_i,
   input  wire logic [5:0] link_release_indication_i,
   output logic      [5:0] link_setup_request_o,
   // identity check and link identification
   input  wire logic       ident_valid_i,
   input  wire logic       ident_match_i,
   input  wire logic       linkid_done_i,
   output logic            ident_request_o,
   output logic            linkid_start_o,
   // restart handshake
   input  wire logic       ctl_restart_complete_i,
   input  wire logic       ctl_restart_request_i,
   input  wire logic       tel_restart_ack_all_i,
   output logic            ctl_restart_request_o,
   output logic            tel_restart_request_o,
   output logic            ctl_restart_complete_o,
   output logic            tel_restart_complete_o,
   // traffic, blocking, maintenance
   output logic            ctl_traffic_start_o,
   output logic            lct_traffic_start_o,
   output logic            ctl_traffic_stop_o,
   output logic            lct_traffic_stop_o,
   output logic            isdn_block_o,
   output logic            tel_port_blocked_o,
   output logic            tel_port_unblocked_o,
   output logic            switchover_o,
   output logic            restart_fail_o,
   output logic            maint_error_o,
   output logic            protection_off_o,
   output logic      [5:0] link_down_o
);
   localparam int NL = `ALSM_NLINK;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      alsm_pkg::alsm_state_e st;
      logic [23:0]           pre;
      logic                  tick;
      logic                  peer;
      logic                  ctl_done;
      logic                  tel_done;
      alsm_pkg::alsm_sec_t   t_tel;
      alsm_pkg::alsm_sec_t   t_ctl;
      alsm_pkg::alsm_sec_t   t_integ;
      alsm_pkg::alsm_sec_t   t_cretry;
      alsm_pkg::alsm_sec_t   t_lretry;
      logic [3:0][8:0]       t_setup;
      logic [5:0]            up;
      logic [5:0]            armed;
      logic [5:0]            req;
      logic [5:0]            down;
      logic                  tel_blocked;
      logic [17:0]           pulses;
   } alsm_st_s;

   alsm_st_s s_r;
   alsm_st_s s_nxt;
   logic [5:0] est;
   logic [5:0] need;

   assign est = link_setup_confirm_i | link_setup_indication_i;
   assign need = {{2{secondary_i}}, tel_prov_i, 3'h7};

   always_comb
   begin
      s_nxt        = s_r;
      s_nxt.pulses = '0;
      s_nxt.req    = '0;
      // exact divider, zero error
      s_nxt.tick = 1'b0;
      if (s_r.pre == 24'(TICK_CYC - 1))
      begin
         s_nxt.pre  = '0;
         s_nxt.tick = 1'b1;
      end
      else
         s_nxt.pre = s_r.pre + 24'h1;
      if (s_r.tick)
      begin
         if (s_r.t_tel != 0)    s_nxt.t_tel    = s_r.t_tel - 9'h1;
         if (s_r.t_ctl != 0)    s_nxt.t_ctl    = s_r.t_ctl - 9'h1;
         if (s_r.t_integ != 0)  s_nxt.t_integ  = s_r.t_integ - 9'h1;
         if (s_r.t_cretry != 0) s_nxt.t_cretry = s_r.t_cretry - 9'h1;
         if (s_r.t_lretry != 0) s_nxt.t_lretry = s_r.t_lretry - 9'h1;
         for (int i = 0; i < 4; i++)
            if (s_r.t_setup[i] != 0)
               s_nxt.t_setup[i] = s_r.t_setup[i] - 9'h1;
      end
      // link bookkeeping
      for (int i = 0; i < NL; i++)
      begin
         if (est[i])
         begin
            s_nxt.up[i]    = 1'b1;
            s_nxt.armed[i] = 1'b1;
            s_nxt.down[i]  = 1'b0;
            if (i < 4) s_nxt.t_setup[2'(i)] = '0;
         end
         else if (link_release_indication_i[i] && need[i])
         begin
            s_nxt.up[i]   = 1'b0;
            s_nxt.down[i] = 1'b1;
            s_nxt.req[i]  = 1'b1;
            s_nxt.pulses[0] = 1'b1;
            if (i < 4 && s_r.armed[i])
            begin
               s_nxt.armed[i]   = 1'b0;
               s_nxt.pulses[1]  = 1'b1;
               s_nxt.t_setup[2'(i)] = 9'(SETUP_S);
            end
         end
      end
      if (est[`ALSM_L_CTL]) s_nxt.pulses[2] = 1'b1;
      if (est[`ALSM_L_LCT]) s_nxt.pulses[3] = 1'b1;
      if (link_setup_indication_i[`ALSM_L_CTL] &&
          (s_r.st == alsm_pkg::ST_ESTAB || s_r.st == alsm_pkg::ST_RUN))
         s_nxt.pulses[4] = 1'b1;
      if (est[`ALSM_L_TEL] && s_r.tel_blocked)
      begin
         s_nxt.tel_blocked = 1'b0;
         s_nxt.pulses[5]   = 1'b1;
      end
      if (s_r.tick && s_r.t_setup[`ALSM_L_TEL] == 9'h1)
      begin
         s_nxt.tel_blocked = 1'b1;
         s_nxt.pulses[6]   = 1'b1;
      end
      if (s_r.tick && s_r.t_setup[`ALSM_L_CTL] == 9'h1)
      begin
         s_nxt.pulses[7]  = 1'b1;
         s_nxt.t_cretry   = 9'(RETRY_S);
      end
      if (s_r.tick && s_r.t_setup[`ALSM_L_LCT] == 9'h1)
      begin
         s_nxt.pulses[8]  = 1'b1;
         s_nxt.t_lretry   = 9'(RETRY_S);
      end
      if (s_r.tick && s_r.t_setup[`ALSM_L_BCC] == 9'h1)
         s_nxt.pulses[0] = 1'b1;
      // keep retrying failed links once a second
      if (s_r.tick)
         s_nxt.req = s_nxt.req | (s_r.down & need);
      if (s_r.down[`ALSM_L_PR1] && s_r.down[`ALSM_L_PR2])
         s_nxt.pulses[9] = 1'b1;
      // restart timer answers
      if (ctl_restart_complete_i)
      begin
         s_nxt.t_ctl    = '0;
         s_nxt.ctl_done = 1'b1;
      end
      if (tel_restart_ack_all_i)
      begin
         s_nxt.t_tel    = '0;
         s_nxt.tel_done = 1'b1;
      end
      unique case (s_r.st)
         alsm_pkg::ST_IDLE:
            if (start_i)
               s_nxt.st = alsm_pkg::ST_ESTAB;
         alsm_pkg::ST_ESTAB:
         begin
            if (s_r.tick)
               s_nxt.req = s_nxt.req | (~s_r.up & need);
            if ((s_r.up & need) == need)
            begin
               s_nxt.st       = alsm_pkg::ST_IDENT;
               s_nxt.pulses[10] = 1'b1;
            end
         end
         alsm_pkg::ST_IDENT:
            if (ident_valid_i)
            begin
               if (ident_match_i)
               begin
                  s_nxt.st         = alsm_pkg::ST_LINKID;
                  s_nxt.pulses[11] = 1'b1;
               end
               else
                  s_nxt.st = alsm_pkg::ST_ABANDON;
            end
         alsm_pkg::ST_LINKID:
            if (linkid_done_i)
               s_nxt.pulses[12] = 1'b1;
         alsm_pkg::ST_RESTART:
         begin
            if (s_r.ctl_done && s_r.tel_done && !s_r.peer)
            begin
               s_nxt.pulses[13] = 1'b1;
               s_nxt.st         = alsm_pkg::ST_RUN;
            end
            else if (s_r.tel_done && s_r.peer)
            begin
               s_nxt.pulses[14] = 1'b1;
               s_nxt.st         = alsm_pkg::ST_RUN;
            end
            else if (s_r.tick && (s_r.t_tel == 9'h1 ||
                     (!s_r.peer && s_r.t_ctl == 9'h1)))
            begin
               if (s_r.peer)
               begin
                  s_nxt.pulses[0] = 1'b1;
                  s_nxt.st        = alsm_pkg::ST_RUN;
               end
               else
               begin
                  s_nxt.pulses[15] = 1'b1;
                  s_nxt.st         = alsm_pkg::ST_ABANDON;
                  s_nxt.t_integ    = 9'(INTEG_S);
               end
               s_nxt.t_tel = '0;
               s_nxt.t_ctl = '0;
            end
         end
         alsm_pkg::ST_RUN: ;
         alsm_pkg::ST_ABANDON:
            if (s_r.tick && s_r.t_integ <= 9'h1)
               s_nxt.st = alsm_pkg::ST_ESTAB;
      endcase
      // restart launch: local, else peer
      if (s_nxt.pulses[12] ||
          (local_restart_i && s_r.st == alsm_pkg::ST_RUN))
      begin
         s_nxt.st = alsm_pkg::ST_RESTART;
         s_nxt.peer = 1'b0;
         s_nxt.ctl_done = 1'b0;
         s_nxt.tel_done = 1'b0;
         s_nxt.pulses[16] = 1'b1;
         s_nxt.t_tel = 9'(TEL_RST_S);
         s_nxt.t_ctl = 9'(CTL_RST_S);
      end
      else if (ctl_restart_request_i && s_r.st == alsm_pkg::ST_RUN)
      begin
         s_nxt.st = alsm_pkg::ST_RESTART;
         s_nxt.peer = 1'b1;
         s_nxt.tel_done = 1'b0;
         s_nxt.pulses[17] = 1'b1;
         s_nxt.t_tel = 9'(TEL_RST_S);
      end
      // retry timer expiry reenters startup
      if (s_r.tick && (s_r.t_cretry == 9'h1 || s_r.t_lretry == 9'h1))
         s_nxt.st = alsm_pkg::ST_ESTAB;
      // a new startup forgets old link state, so every needed link is asked again
      if (s_nxt.st == alsm_pkg::ST_ESTAB && s_r.st != alsm_pkg::ST_ESTAB)
         s_nxt.up = '0;
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign link_setup_request_o   = s_r.req;
   assign switchover_o           = s_r.pulses[1];
   assign maint_error_o          = s_r.pulses[0];
   assign ctl_traffic_start_o    = s_r.pulses[2] | s_r.pulses[4];
   assign lct_traffic_start_o    = s_r.pulses[3];
   assign ident_request_o        = s_r.pulses[10] | s_r.pulses[4];
   assign linkid_start_o         = s_r.pulses[11];
   assign tel_port_unblocked_o   = s_r.pulses[5];
   assign tel_port_blocked_o     = s_r.pulses[6];
   assign ctl_traffic_stop_o     = s_r.pulses[7];
   assign isdn_block_o           = s_r.pulses[7];
   assign lct_traffic_stop_o     = s_r.pulses[8];
   assign protection_off_o       = s_r.pulses[9];
   assign restart_fail_o         = s_r.pulses[15];
   assign ctl_restart_request_o  = s_r.pulses[16];
   assign tel_restart_request_o  = s_r.pulses[16] | s_r.pulses[17];
   assign tel_restart_complete_o = s_r.pulses[13] | s_r.pulses[14];
   assign ctl_restart_complete_o = s_r.pulses[14];
   assign link_down_o            = s_r.down;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_TEL_GATE: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      !tel_prov_i |-> !link_setup_request_o[`ALSM_L_TEL])
      else $error("telephony link requested while unprovisioned");
   AST_LOC_RST: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      ctl_restart_request_o |-> tel_restart_request_o && s_r.t_ctl != 0
      && s_r.t_tel != 0)
      else $error("local restart incomplete");
   AST_CTL_STOP: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      ctl_restart_complete_i |=> s_r.t_ctl == 0)
      else $error("control restart timer not stopped");
   AST_COMPLETE: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      $rose(tel_restart_complete_o) |-> $past(s_r.tel_done))
      else $error("restart complete without acknowledgements");
   AST_FAIL: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      restart_fail_o |-> s_r.st == alsm_pkg::ST_ABANDON)
      else $error("failed restart not abandoned");
   AST_PEER: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      ctl_restart_request_i && s_r.st == alsm_pkg::ST_RUN
      |=> tel_restart_request_o && !ctl_restart_request_o)
      else $error("peer restart not forwarded");
   AST_SWITCH: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      switchover_o |-> maint_error_o)
      else $error("switch-over without error report");
   AST_ONE_SW: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      switchover_o ##1 (!(|est))[*2] |-> !switchover_o)
      else $error("repeated switch-over");
   AST_STOP: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      ctl_traffic_stop_o |-> isdn_block_o && s_r.t_cretry != 0)
      else $error("control expiry incomplete");
   AST_LCT_START: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      link_setup_confirm_i[`ALSM_L_LCT] |=> lct_traffic_start_o)
      else $error("link control traffic not started");
   AST_PROT_GATE: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      !secondary_i |-> link_setup_request_o[`ALSM_L_PR2:`ALSM_L_PR1] == 2'h0)
      else $error("protection link requested without secondary");
   AST_PROT_BOTH: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      protection_off_o |-> $past(link_down_o[`ALSM_L_PR1])
      && $past(link_down_o[`ALSM_L_PR2]))
      else $error("protection disabled without double failure");
   AST_PEER_DONE: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      tel_restart_ack_all_i && s_r.st == alsm_pkg::ST_RESTART && s_r.peer
      && !s_r.tel_done && !(s_r.tick && s_r.t_tel == 9'h1)
      |-> ##2 ctl_restart_complete_o && tel_restart_complete_o)
      else $error("peer restart not completed");
endmodule // alsm_top

// ===== tb/alsm_far_model.sv
module alsm_far_model (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   // bench control
   input  wire logic [5:0] link_en_i,
   input  wire logic       answer_en_i,
   input  wire logic [3:0] delay_i,
   // requests from the manager
   input  wire logic [5:0] setup_req_i,
   input  wire logic       ctl_rst_req_i,
   input  wire logic       tel_rst_req_i,
   // answers
   output logic      [5:0] setup_cfm_o,
   output logic            ctl_done_o,
   output logic            tel_ack_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] req;
   logic [7:0] en;
   logic [7:0] ans_r;
   int         cnt [8];
   assign req = {tel_rst_req_i, ctl_rst_req_i, setup_req_i};
   assign en  = {answer_en_i, answer_en_i, link_en_i};
   assign {tel_ack_o, ctl_done_o, setup_cfm_o} = ans_r;
   // muted channels swallow the request and never answer
   always @(posedge clk_i or negedge resetn_i)
   begin
      for (int i = 0; i < 8; i++)
      begin
         ans_r[i] <= 1'b0;
         if (!resetn_i)
            cnt[i] <= 0;
         else if (cnt[i] == 1)
         begin
            cnt[i] <= 0;
            ans_r[i] <= en[i];
         end
         else if (cnt[i] > 1)
            cnt[i] <= cnt[i] - 1;
         else if (req[i] === 1'b1)
            cnt[i] <= int'(delay_i) + 1;
      end
   end
endmodule // alsm_far_model

// ===== tb/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i    = 1'b0;
   logic        resetn_i = 1'b0;
   logic        st       = 1'b0;
   logic        tp       = 1'b0;
   logic        sc       = 1'b0;
   logic        an       = 1'b1;
   logic        clr      = 1'b1;
   logic [10:0] pv       = '0;
   logic [5:0]  en       = 6'h3F;
   logic [3:0]  dl       = 4'h1;
   logic [23:0] sk       = '0;
   logic [5:0]  ind      = '0;
   logic [5:0]  cfm;
   logic        ctl_done;
   logic        tel_ack;
   wire  [23:0] ev;
   wire  [5:0]  down;
   int          bad_count = 0;
   int          checks    = 0;
   int          t;
   assign ev[16] = |ev[22:17];
   initial
   begin
      forever #50 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
      sk <= clr ? '0 : (sk | ev);
   alsm_top #(
      .TICK_CYC (10)
   ) alsm_top_i (
      .clk_i                     (clk_i),
      .resetn_i                  (resetn_i),
      .start_i                   (st),
      .tel_prov_i                (tp),
      .secondary_i               (sc),
      .local_restart_i           (pv[3]),
      .link_setup_confirm_i      (cfm),
      .link_setup_indication_i   (ind),
      .link_release_indication_i (pv[10:5]),
      .link_setup_request_o      (ev[22:17]),
      .ident_valid_i             (pv[0]),
      .ident_match_i             (pv[1]),
      .linkid_done_i             (pv[2]),
      .ident_request_o           (ev[0]),
      .linkid_start_o            (ev[1]),
      .ctl_restart_complete_i    (ctl_done),
      .ctl_restart_request_i     (pv[4]),
      .tel_restart_ack_all_i     (tel_ack),
      .ctl_restart_request_o     (ev[2]),
      .tel_restart_request_o     (ev[3]),
      .ctl_restart_complete_o    (ev[4]),
      .tel_restart_complete_o    (ev[5]),
      .ctl_traffic_start_o       (ev[6]),
      .lct_traffic_start_o       (ev[23]),
      .ctl_traffic_stop_o        (ev[7]),
      .lct_traffic_stop_o        (ev[8]),
      .isdn_block_o              (ev[9]),
      .tel_port_blocked_o        (ev[10]),
      .tel_port_unblocked_o      (ev[11]),
      .switchover_o              (ev[12]),
      .restart_fail_o            (ev[13]),
      .maint_error_o             (ev[14]),
      .protection_off_o          (ev[15]),
      .link_down_o               (down)
   );
   alsm_far_model alsm_far_model_i (
      .clk_i         (clk_i),
      .resetn_i      (resetn_i),
      .link_en_i     (en),
      .answer_en_i   (an),
      .delay_i       (dl),
      .setup_req_i   (ev[22:17]),
      .ctl_rst_req_i (ev[2]),
      .tel_rst_req_i (ev[3]),
      .setup_cfm_o   (cfm),
      .ctl_done_o    (ctl_done),
      .tel_ack_o     (tel_ack)
   );
   // ----------------------------------------
   // shared helpers
   // ----------------------------------------
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic ck(input logic c, input string m);
      checks++;
      if (c !== 1'b1)
      begin
         bad_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   // t counts cycles to the event, t_peer and t_lrst check it right after
   task automatic wt(input int i, input int n);
      t = 0;
      do
      begin
         @(negedge clk_i);
         t++;
         if (t > n)
         begin
            ck(1'b0, "wait ran out");
            close_out;
         end
      end
      while (ev[i] !== 1'b1);
   endtask
   task automatic pm(input logic [10:0] m);
      @(posedge clk_i);
      pv <= m;
      @(posedge clk_i);
      pv <= '0;
   endtask
   task automatic cl;
      @(posedge clk_i);
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
   endtask
   task automatic up(input logic tel, input logic sec);
      @(posedge clk_i);
      resetn_i <= 1'b0;
      clr <= 1'b1;
      st <= 1'b0;
      tp <= tel;
      sc <= sec;
      en <= 6'h3F;
      an <= 1'b1;
      repeat (8) @(posedge clk_i);
      resetn_i <= 1'b1;
      clr <= 1'b0;
      st <= 1'b1;
      wt(0, 400);
      ck(sk[22:17] === {sec, sec, tel, 3'h7}, "requests");
      ck(sk[6] === 1'b1, "no traffic start");
      ck(sk[23] === 1'b1, "no linkctl start");
      pm(11'h003);
      wt(1, 3);
      pm(11'h004);
      wt(2, 3);
      ck(ev[3] === 1'b1, "no tel restart");
      wt(5, 60);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_start;
      up(1'b1, 1'b1);
      $display("test startup done");
   endtask
   task automatic t_notel;
      up(1'b0, 1'b0);
      $display("test no telephony done");
   endtask
   task automatic t_peer;
      up(1'b1, 1'b1);
      dl <= 4'h7;
      cl;
      pm(11'h010);
      wt(3, 3);
      wt(4, 40);
      repeat (2) @(negedge clk_i);
      ck(sk[5] === 1'b1, "no tel complete");
      ck(sk[2] === 1'b0, "ctl request sent");
      an <= 1'b0;
      pm(11'h010);
      wt(14, 1100);
      ck(t > 940 && t < 1060, "tel timer");
      $display("test peer restart done");
   endtask
   task automatic t_lrst;
      up(1'b1, 1'b1);
      an <= 1'b0;
      pm(11'h008);
      wt(2, 3);
      ck(ev[3] === 1'b1, "no tel restart");
      wt(13, 1100);
      ck(t > 940 && t < 1060, "restart timer");
      an <= 1'b1;
      wt(16, 3200);
      ck(t > 2840, "integrity period");
      $display("test local restart done");
   endtask
   task automatic t_tel;
      up(1'b1, 1'b1);
      en <= 6'h37;
      pm(11'h100);
      wt(12, 3);
      ck(ev[14] === 1'b1, "no maint error");
      @(negedge clk_i);
      ck(down[3] === 1'b1, "link not down");
      cl;
      pm(11'h100);
      repeat (4) @(negedge clk_i);
      ck(sk[12] === 1'b0, "second switch");
      wt(10, 200);
      en <= 6'h3F;
      wt(11, 40);
      repeat (2) @(negedge clk_i);
      ck(down[3] === 1'b0, "link still down");
      $display("test telephony link done");
   endtask
   task automatic t_lnk(input int i);
      up(1'b1, 1'b1);
      en <= ~(6'h01 << i);
      pm(11'h020 << i);
      wt(7 + i, 200);
      repeat (2) @(negedge clk_i);
      ck(sk[9] === (i == 0), "port blocking");
      cl;
      repeat (500) @(negedge clk_i);
      ck(sk[19] === 1'b0, "early startup");
      repeat (200) @(negedge clk_i);
      ck(sk[19] === 1'b1, "no new startup");
      $display("test link %0d done", i);
   endtask
   task automatic t_ind;
      up(1'b1, 1'b0);
      cl;
      @(posedge clk_i);
      ind <= 6'h01;
      @(posedge clk_i);
      ind <= 6'h00;
      wt(0, 3);
      ck(ev[6] === 1'b1, "no control start");
      $display("test control indication done");
   endtask
   task automatic t_prot;
      up(1'b1, 1'b1);
      en <= 6'h0F;
      cl;
      pm(11'h200);
      wt(14, 3);
      repeat (2) @(negedge clk_i);
      ck(sk[15] === 1'b0, "protection off early");
      pm(11'h400);
      wt(15, 3);
      $display("test protection done");
   endtask
   initial
   begin
      t_start;
      t_notel;
      t_peer;
      t_lrst;
      t_tel;
      t_lnk(0);
      t_lnk(1);
      t_prot;
      t_ind;
      close_out;
   end
endmodule // tb_top
